/* File: bench/scm_host_model.sv */
// scm_host_model: register bus host on the far side of the slave.
// assumes a free running pclk; the bench calls xfer by hierarchy.
`timescale 1ns/1ps
module scm_host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // ==========================================================
  // one transfer; sole device on the bus, so no address clash
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err, output logic ok);
    int n;
    ok  = 1'b0;
    rd  = 32'h0;
    err = 1'b0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
      begin
        ok = 1'b1;
        break;
      end
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released lines show a changed value, not the last one
    pwrite  <= ~wr;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule // scm_host_model

/* File: bench/tb_top.sv */
// tb_top: self-checking bench of the start-up and configuration manager.
// assumes host model owns the register bus; other pins driven here.
`timescale 1ns/1ps
module tb_top
  import scm_pkg::*;
  ;
  localparam int unsigned LOG_P  = 5;
  localparam int unsigned BBOX_P = 10;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0]  strap = 3'h0;
  logic        reset_pin_n = 1'b1;
  logic        brownout_in = 1'b0;
  logic        shutdown_in = 1'b0;
  logic        cfg_csum_ok = 1'b1;
  logic [7:0]  log_ok = 8'hff;
  logic        fault_evt = 1'b0;
  logic [7:0]  slave_addr, log_keep;
  logic        ref_ext_sel, bus_alert_n, io_hiz, seq_enable;
  logic        snap_save, ee_wr_entry, ee_wr_bbox;
  int          err_count = 0;
  int          cmp_count = 0;

  always #25 pclk = ~pclk;

  scm_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // short counts keep the run small
  scm_top #(.INIT_CYC_P(50), .LOG_WR_CYC_P(LOG_P),
    .BBOX_CYC_P(BBOX_P), .LOG_N(8)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .addr_strap_msb(strap[2]),
    .addr_strap_mid(strap[1]), .addr_strap_lsb(strap[0]),
    .reset_pin_n(reset_pin_n), .brownout_in(brownout_in),
    .shutdown_in(shutdown_in), .cfg_csum_ok(cfg_csum_ok),
    .log_entry_ok(log_ok), .fault_evt(fault_evt),
    .slave_addr(slave_addr), .ref_ext_sel(ref_ext_sel),
    .bus_alert_n(bus_alert_n), .io_hiz(io_hiz),
    .seq_enable(seq_enable), .log_keep(log_keep),
    .snap_save(snap_save), .ee_wr_entry(ee_wr_entry),
    .ee_wr_bbox(ee_wr_bbox));

  // ==========================================================
  // helpers
  function automatic logic [7:0] exp_addr(input logic [2:0] c);
    case (c)
      3'h0: return 8'h11;
      3'h1: return 8'h13;
      3'h2: return 8'h17;
      3'h3: return 8'h31;
      3'h4: return 8'h33;
      3'h5: return 8'h71;
      3'h6: return 8'h73;
      default: return 8'h77;
    endcase
  endfunction

  task automatic final_report();
    if (err_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    logic ok;
    host.xfer(wr, a, d, rd, err, ok);
    if (ok !== 1'b1)
    begin
      check("pready_wait", 32'h0, 32'h1);
      final_report();
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp, input string name);
    logic [31:0] rd;
    logic        err;
    bus(1'b0, a, 32'h0, rd, err);
    check(name, rd & m, exp);
  endtask

  task automatic wait_boot();
    logic [31:0] rd;
    logic        err;
    repeat (60) @(posedge pclk);
    #1;
    check("io_hiz_init", 32'(io_hiz), 32'h1);
    bus(1'b1, OFS_CFG_RAM, 32'h0, rd, err);
    check("init_write_refused", 32'(err), 32'h1);
    repeat (42) @(posedge pclk);
    #1;
  endtask

  task automatic por_boot();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    wait_boot();
  endtask

  task automatic pin_boot();
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    repeat (25) @(posedge pclk);
    reset_pin_n <= 1'b1;
    wait_boot();
  endtask

  task automatic pulse_fault();
    @(posedge pclk);
    fault_evt <= 1'b1;
    @(posedge pclk);
    fault_evt <= 1'b0;
    #1;
  endtask

  // cycles until the commit level rises, then cycles it stays high
  task automatic hi_len(input bit bbox, output int wt, output int len);
    wt  = 0;
    len = 0;
    while ((bbox ? ee_wr_bbox : ee_wr_entry) !== 1'b1 && wt < 300)
    begin
      @(posedge pclk);
      #1;
      wt++;
    end
    while ((bbox ? ee_wr_bbox : ee_wr_entry) === 1'b1 && len < 300)
    begin
      @(posedge pclk);
      #1;
      len++;
    end
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    logic [31:0] rd;
    logic [31:0] f0;
    logic        err;
    int          wt;
    int          len;
    logic [15:0] img;
    void'($urandom(36322));
    for (int c = 0; c < 8; c++)
    begin
      strap  <= 3'(c);
      log_ok <= 8'($urandom);
      por_boot();
      check("slave_addr", 32'(slave_addr), 32'(exp_addr(3'(c))));
      rd_chk(OFS_STATUS, 32'h0000ff00,
             32'(exp_addr(3'(c))) << ST_ADDR_LSB, "status_addr");
      check("log_keep", 32'(log_keep), 32'(log_ok));
      check("ref_default", 32'(ref_ext_sel), 32'h0);
      strap <= ~strap;
      repeat (10) @(posedge pclk);
      #1;
      check("addr_hold", 32'(slave_addr), 32'(exp_addr(3'(c))));
    end
    // staged configuration, then store-all
    bus(1'b0, OFS_FLASH, 32'h0, f0, err);
    check("flash_blank", f0 & 32'h0000ffff, 32'(CFG_RST));
    check("io_hiz_boot", 32'(io_hiz), 32'h1);
    check("seq_boot", 32'(seq_enable), 32'h0);
    // external reference taken as present before it is chosen
    bus(1'b1, OFS_CFG_RAM, 32'h3, rd, err);
    rd_chk(OFS_CFG_RAM, 32'h0000ffff, 32'h3, "cfg_ram");
    rd_chk(OFS_FLASH, 32'h0000ffff, f0 & 32'h0000ffff, "flash_kept");
    bus(1'b1, OFS_CMD, 32'h1 << CMD_STORE_BIT, rd, err);
    rd_chk(OFS_FLASH, 32'h0000ffff, 32'h3, "flash_stored");
    check("ref_pending", 32'(ref_ext_sel), 32'h0);
    pin_boot();
    check("ref_after_reset", 32'(ref_ext_sel), 32'h1);
    check("io_hiz_run", 32'(io_hiz), 32'h0);
    check("seq_run", 32'(seq_enable), 32'h1);
    rd_chk(OFS_STATUS, 32'h18, 32'h18, "status_active");
    // full image download acts only after reset
    img = 16'($urandom);
    bus(1'b1, OFS_IMAGE, 32'(img), rd, err);
    rd_chk(OFS_IMAGE, 32'h0000ffff, 32'(img), "image_rw");
    bus(1'b1, OFS_IMAGE, 32'h2, rd, err);
    bus(1'b1, OFS_CMD, 32'h1 << CMD_IMAGE_BIT, rd, err);
    rd_chk(OFS_FLASH, 32'h0000ffff, 32'h2, "flash_image");
    check("ref_image_pending", 32'(ref_ext_sel), 32'h1);
    pin_boot();
    check("ref_image_applied", 32'(ref_ext_sel), 32'h0);
    check("io_hiz_image", 32'(io_hiz), 32'h0);
    // corrupt configuration checksum
    cfg_csum_ok <= 1'b0;
    pin_boot();
    cfg_csum_ok <= 1'b1;
    check("alert_low", 32'(bus_alert_n), 32'h0);
    rd_chk(OFS_STATUS, 32'h1, 32'h1, "csum_flag");
    rd_chk(OFS_FLASH, 32'h0000ffff, 32'h0, "flash_erased");
    check("io_hiz_erased", 32'(io_hiz), 32'h1);
    check("seq_erased", 32'(seq_enable), 32'h0);
    bus(1'b1, OFS_STATUS, 32'h1 << ST_CSUM_BIT, rd, err);
    @(posedge pclk);
    #1;
    check("alert_cleared", 32'(bus_alert_n), 32'h1);
    bus(1'b0, 8'h3c, 32'h0, rd, err);
    check("unmapped_err", 32'(err), 32'h1);
    check("unmapped_data", rd, 32'h0);
    // first fault: entry commit, then snapshot
    pulse_fault();
    check("snap_first", 32'(snap_save), 32'h1);
    hi_len(1'b0, wt, len);
    check("entry_len", 32'(len), LOG_P);
    hi_len(1'b1, wt, len);
    check("bbox_gap", 32'(wt <= 2), 32'h1);
    check("bbox_len", 32'(len), BBOX_P);
    // brownout with several pending faults
    // enough faults that some are still waiting when shutdown hits
    repeat (6) pulse_fault();
    check("snap_once", 32'(snap_save), 32'h0);
    brownout_in <= 1'b1;
    hi_len(1'b0, wt, len);
    hi_len(1'b0, wt, len);
    check("entry_in_brownout", 32'(len), LOG_P);
    rd_chk(OFS_STATUS, 32'h4, 32'h4, "status_brownout");
    @(posedge pclk);
    shutdown_in <= 1'b1;
    repeat (10) @(posedge pclk);
    #1;
    check("entry_stopped", 32'(ee_wr_entry), 32'h0);
    rd_chk(OFS_LOG, 32'h00ff0000, 32'h0, "pending_lost");
    repeat (20) @(posedge pclk);
    #1;
    check("entry_still_off", 32'(ee_wr_entry), 32'h0);
    final_report();
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    check("watchdog", 32'h0, 32'h1);
    final_report();
  end
endmodule // tb_top

/* File: common/scm_pkg.sv */
// scm_pkg: constants, register map and state encoding of the
// start-up and configuration manager.
// assumes a 20 MHz pclk; all timing counts derive from its period.
package scm_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned INIT_TIME_NS  = 27_500_000;
  localparam int unsigned LOG_WR_NS     = 500_000;
  localparam int unsigned BBOX_WR_NS    = 4_000_000;
  localparam int unsigned RST_MIN_NS    = 1_000;
  localparam int unsigned RECOV_NS      = 2_000;
  localparam int unsigned INIT_CYC   = INIT_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned LOG_WR_CYC = LOG_WR_NS / CLK_PERIOD_NS;
  localparam int unsigned BBOX_CYC   = BBOX_WR_NS / CLK_PERIOD_NS;
  localparam int unsigned RST_MIN_CYC =
    (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOV_CYC  = RECOV_NS / CLK_PERIOD_NS;

  // ==========================================================
  // strap code to slave address
  localparam logic [7:0] ADDR_LUT [0:7] = '{
    8'h11, 8'h13, 8'h17, 8'h31, 8'h33, 8'h71, 8'h73, 8'h77};

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] OFS_CFG_RAM = 8'h00;
  localparam logic [7:0] OFS_CMD     = 8'h04;
  localparam logic [7:0] OFS_IMAGE   = 8'h08;
  localparam logic [7:0] OFS_FLASH   = 8'h0c;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_LOG     = 8'h14;

  // config word fields
  localparam int unsigned CFG_EXT_REF_BIT = 0;
  localparam int unsigned CFG_VALID_BIT   = 1;
  localparam int unsigned CFG_W           = 16;
  localparam logic [15:0] CFG_RST         = 16'h0000;

  // command bits
  localparam int unsigned CMD_STORE_BIT = 0;
  localparam int unsigned CMD_IMAGE_BIT = 1;

  // status fields
  localparam int unsigned ST_CSUM_BIT  = 0;
  localparam int unsigned ST_INIT_BIT  = 1;
  localparam int unsigned ST_BO_BIT    = 2;
  localparam int unsigned ST_REF_BIT   = 3;
  localparam int unsigned ST_CFGD_BIT  = 4;
  localparam int unsigned ST_ADDR_LSB  = 8;

  // ==========================================================
  // control states
  typedef enum logic [4:0] {
    ST_RHOLD = 5'h01,
    ST_INIT  = 5'h02,
    ST_RUN   = 5'h04,
    ST_BROWN = 5'h08,
    ST_OFF   = 5'h10
  } scm_state_t;

endpackage

/* File: design/scm_top.sv */
// scm_top: start-up, reset, brownout logging and configuration
// staging of a multi-rail sequencer, with an APB register slave.
// assumes straps, reset pin, brownout and shutdown levels are async;
// checksum results and fault events come from logic on pclk.
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
module scm_top
  import scm_pkg::*;
#(
  parameter int unsigned INIT_CYC_P   = INIT_CYC,
  parameter int unsigned LOG_WR_CYC_P = LOG_WR_CYC,
  parameter int unsigned BBOX_CYC_P   = BBOX_CYC,
  parameter int unsigned LOG_N        = 8
)(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             addr_strap_msb,
  input  wire logic             addr_strap_mid,
  input  wire logic             addr_strap_lsb,
  input  wire logic             reset_pin_n,
  input  wire logic             brownout_in,
  input  wire logic             shutdown_in,
  input  wire logic             cfg_csum_ok,
  input  wire logic [LOG_N-1:0] log_entry_ok,
  input  wire logic             fault_evt,
  output logic [7:0]            slave_addr,
  output logic                  ref_ext_sel,
  output logic                  bus_alert_n,
  output logic                  io_hiz,
  output logic                  seq_enable,
  output logic [LOG_N-1:0]      log_keep,
  output logic                  snap_save,
  output logic                  ee_wr_entry,
  output logic                  ee_wr_bbox
);

  // ==========================================================
  // parameter checks
  if (INIT_CYC_P < 2 || LOG_WR_CYC_P < 1 || BBOX_CYC_P < 1)
    $error("scm_top: timing counts too small");
  if (LOG_N < 1 || LOG_N > 16)
    $error("scm_top: LOG_N must be 1..16");

  // ==========================================================
  // state
  typedef struct packed {
    logic [2:0]        strap_s1;
    logic [2:0]        strap_s2;
    logic              rpin_s1;
    logic              rpin_s2;
    logic              bo_s1;
    logic              bo_s2;
    logic              sd_s1;
    logic              sd_s2;
    scm_state_t        st;
    logic [31:0]       cnt;
    logic [31:0]       rlow;
    logic [CFG_W-1:0]  cfg_ram;
    logic [CFG_W-1:0]  flash;
    logic [CFG_W-1:0]  image;
    logic [CFG_W-1:0]  act_cfg;
    logic [7:0]        addr;
    logic              ext_ref;
    logic              csum_err;
    logic [LOG_N-1:0]  keep;
    logic [7:0]        pending;
    logic              bbox_pend;
    logic              bbox_done;
    logic              ent1;
    logic              snap;
    logic [1:0]        wr;
    logic [31:0]       wcnt;
    logic [31:0]       rdata;
  } scm_st_t;

  scm_st_t q;
  scm_st_t d;

  logic acc;
  logic wr_acc;
  logic mapped;
  logic in_run;

  assign acc    = psel && penable;
  assign in_run = (q.st == ST_RUN);
  assign mapped = (paddr == OFS_CFG_RAM) || (paddr == OFS_CMD) ||
                  (paddr == OFS_IMAGE) || (paddr == OFS_FLASH) ||
                  (paddr == OFS_STATUS) || (paddr == OFS_LOG);
  // writes only while running: config is frozen during start-up
  assign wr_acc = acc && pwrite && mapped && in_run;

  assign pready  = 1'b1;
  assign pslverr = acc && (!mapped || (pwrite && !in_run));

  // ==========================================================
  // next state
  always_comb
  begin
    d = q;
    d.snap = 1'b0;
    d.strap_s1 = {addr_strap_msb, addr_strap_mid, addr_strap_lsb};
    d.strap_s2 = q.strap_s1;
    d.rpin_s1  = reset_pin_n;
    d.rpin_s2  = q.rpin_s1;
    d.bo_s1    = brownout_in;
    d.bo_s2    = q.bo_s1;
    d.sd_s1    = shutdown_in;
    d.sd_s2    = q.sd_s1;

    // fault capture only while running normally
    if (in_run && fault_evt)
    begin
      if (q.pending != 8'hff)
        d.pending = q.pending + 8'h01;
      if (!q.bbox_done)
      begin
        d.bbox_done = 1'b1;
        d.bbox_pend = 1'b1;
        d.snap      = 1'b1;
        d.ent1      = 1'b0;
      end
    end

    // eeprom commit engine: entry first, then snapshot, then rest
    if (q.st == ST_RUN || q.st == ST_BROWN)
    begin
      if (q.wr != 2'd0)
      begin
        if (q.wcnt <= 32'd1)
        begin
          d.wr = 2'd0;
          if (q.wr == 2'd1)
          begin
            d.pending = d.pending - 8'h01;
            d.ent1    = 1'b1;
          end
          else
            d.bbox_pend = 1'b0;
        end
        else
          d.wcnt = q.wcnt - 32'd1;
      end
      else if (q.bbox_pend && (q.ent1 || q.pending == 8'h00))
      begin
        d.wr   = 2'd2;
        d.wcnt = BBOX_CYC_P;
      end
      else if (q.pending != 8'h00)
      begin
        d.wr   = 2'd1;
        d.wcnt = LOG_WR_CYC_P;
      end
    end

    case (q.st)
      ST_RHOLD:
      begin
        if (q.rpin_s2)
        begin
          if (q.cnt + 32'd1 >= RECOV_CYC)
          begin
            d.st  = ST_INIT;
            d.cnt = INIT_CYC_P - 32'd1;
            // straps and reference bit caught once here
            d.addr    = ADDR_LUT[q.strap_s2];
            d.ext_ref = q.flash[CFG_EXT_REF_BIT];
            d.act_cfg = q.flash;
          end
          else
            d.cnt = q.cnt + 32'd1;
        end
        else
          d.cnt = 32'd0;
      end
      ST_INIT:
      begin
        if (q.cnt == INIT_CYC_P - 32'd1)
        begin
          d.keep = log_entry_ok;
          if (!cfg_csum_ok)
          begin
            d.flash    = CFG_RST;
            d.act_cfg  = CFG_RST;
            d.ext_ref  = 1'b0;
            d.csum_err = 1'b1;
          end
        end
        if (q.cnt == 32'd0)
          d.st = ST_RUN;
        else
          d.cnt = q.cnt - 32'd1;
      end
      ST_RUN:
      begin
        if (q.bo_s2)
          d.st = ST_BROWN;
      end
      ST_BROWN:
      begin
        if (q.sd_s2)
        begin
          d.st        = ST_OFF;
          d.pending   = 8'h00;
          d.bbox_pend = 1'b0;
          d.wr        = 2'd0;
        end
      end
      ST_OFF:
      begin
        d.pending = 8'h00;
      end
      default:
      begin
        d.st = ST_RHOLD;
      end
    endcase

    // reset pin held low long enough forces a full restart
    if (!q.rpin_s2)
    begin
      if (q.rlow + 32'd1 >= RST_MIN_CYC)
      begin
        d.st        = ST_RHOLD;
        d.cnt       = 32'd0;
        d.pending   = 8'h00;
        d.bbox_pend = 1'b0;
        d.wr        = 2'd0;
      end
      else
        d.rlow = q.rlow + 32'd1;
    end
    else
      d.rlow = 32'd0;

    // register writes: staging only, flash via commands
    if (wr_acc)
    begin
      case (paddr)
        OFS_CFG_RAM: d.cfg_ram = pwdata[CFG_W-1:0];
        OFS_IMAGE:   d.image   = pwdata[CFG_W-1:0];
        OFS_CMD:
        begin
          if (pwdata[CMD_STORE_BIT])
            d.flash = q.cfg_ram;
          else if (pwdata[CMD_IMAGE_BIT])
            d.flash = q.image;
        end
        OFS_STATUS:
        begin
          // no clash with set: clear only applies in run, set only in init
          if (pwdata[ST_CSUM_BIT])
            d.csum_err = 1'b0;
        end
        default: d.cnt = d.cnt;
      endcase
    end

    // read data captured in setup phase
    d.rdata = 32'h0000_0000;
    if (psel && !penable)
    begin
      case (paddr)
        OFS_CFG_RAM: d.rdata[CFG_W-1:0] = q.cfg_ram;
        OFS_IMAGE:   d.rdata[CFG_W-1:0] = q.image;
        OFS_FLASH:   d.rdata[CFG_W-1:0] = q.flash;
        OFS_STATUS:
        begin
          d.rdata[ST_CSUM_BIT] = q.csum_err;
          d.rdata[ST_INIT_BIT] = (q.st == ST_INIT);
          d.rdata[ST_BO_BIT]   = (q.st == ST_BROWN);
          d.rdata[ST_REF_BIT]  = q.ext_ref;
          d.rdata[ST_CFGD_BIT] = q.act_cfg[CFG_VALID_BIT];
          d.rdata[ST_ADDR_LSB +: 8] = q.addr;
        end
        OFS_LOG:
        begin
          d.rdata[LOG_N-1:0] = q.keep;
          d.rdata[23:16]     = q.pending;
        end
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    else if (psel)
      d.rdata = q.rdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q     <= '0;
      q.st  <= ST_RHOLD;
      q.rpin_s1 <= 1'b1;
      q.rpin_s2 <= 1'b1;
      q.addr    <= 8'h00;
    end
    else
      q <= d;
  end

  // ==========================================================
  // outputs
  assign prdata      = q.rdata;
  assign slave_addr  = q.addr;
  // analog supply reference unless the latched bit says otherwise
  assign ref_ext_sel = q.ext_ref;
  assign bus_alert_n = !q.csum_err;
  assign io_hiz      = !(q.st == ST_RUN || q.st == ST_BROWN) ||
                       !q.act_cfg[CFG_VALID_BIT];
  assign seq_enable  = in_run && q.act_cfg[CFG_VALID_BIT];
  assign log_keep    = q.keep;
  assign snap_save   = q.snap;
  assign ee_wr_entry = (q.wr == 2'd1);
  assign ee_wr_bbox  = (q.wr == 2'd2);

  // ==========================================================
  // assertions
  property p_addr_map;
    @(posedge pclk) disable iff (!presetn)
    $rose(q.st == ST_INIT) |-> q.addr == ADDR_LUT[$past(q.strap_s2)];
  endproperty
  a_addr_map: assert property (p_addr_map)
    else $error("slave address does not match strap code");

  property p_addr_hold;
    @(posedge pclk) disable iff (!presetn)
    // checksum erase may drop the reference once, in the first init
    // cycle; from then on both stay put
    (q.st != ST_RHOLD) && $past(q.st != ST_RHOLD) &&
      !$past(q.st == ST_INIT && q.cnt == INIT_CYC_P - 32'd1) |->
      $stable(slave_addr) && $stable(ref_ext_sel);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address or reference changed outside reset");

  property p_hiz_init;
    @(posedge pclk) disable iff (!presetn)
    (q.st == ST_INIT) |-> io_hiz && !seq_enable;
  endproperty
  a_hiz_init: assert property (p_hiz_init)
    else $error("pins driven during initialization");

  property p_run_entry;
    @(posedge pclk) disable iff (!presetn)
    $rose(q.st == ST_RUN) |->
      $past(q.st) == ST_INIT && $past(q.cnt) == 32'd0;
  endproperty
  a_run_entry: assert property (p_run_entry)
    else $error("run entered without full initialization");

  property p_csum;
    @(posedge pclk) disable iff (!presetn)
    (q.st == ST_INIT) && (q.cnt == INIT_CYC_P - 32'd1) && !cfg_csum_ok
      |=> !bus_alert_n && q.flash == CFG_RST && q.csum_err;
  endproperty
  a_csum: assert property (p_csum)
    else $error("checksum failure not handled");

  property p_store;
    @(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == OFS_CMD && pwdata[CMD_STORE_BIT]
      |=> q.flash == $past(q.cfg_ram);
  endproperty
  a_store: assert property (p_store)
    else $error("store-all did not copy ram to flash");

  property p_image;
    @(posedge pclk) disable iff (!presetn)
    in_run && $past(in_run) |-> $stable(q.act_cfg);
  endproperty
  a_image: assert property (p_image)
    else $error("active config changed while running");

  property p_off;
    @(posedge pclk) disable iff (!presetn)
    (q.st == ST_BROWN) && q.sd_s2 && q.rpin_s2
      |=> q.pending == 8'h00 && !ee_wr_entry && !ee_wr_bbox;
  endproperty
  a_off: assert property (p_off)
    else $error("pending faults kept past shutdown");

  property p_bo_no_new;
    @(posedge pclk) disable iff (!presetn)
    (q.st == ST_BROWN) |=> q.pending <= $past(q.pending);
  endproperty
  a_bo_no_new: assert property (p_bo_no_new)
    else $error("new fault accepted during brownout");

  property p_bbox_order;
    @(posedge pclk) disable iff (!presetn)
    $rose(ee_wr_bbox) |-> $past(q.ent1) || $past(q.pending) == 8'h00;
  endproperty
  a_bbox_order: assert property (p_bbox_order)
    else $error("snapshot written before first entry");

  property p_pin_rst;
    @(posedge pclk) disable iff (!presetn)
    !q.rpin_s2 && q.rlow + 32'd1 >= RST_MIN_CYC |=> q.st == ST_RHOLD;
  endproperty
  a_pin_rst: assert property (p_pin_rst)
    else $error("reset pin did not reset the device");

endmodule // scm_top
